// [inc/dsgc_pkg.sv]
// package: offsets, field positions, reset values and carriers
package dsgc_pkg;

  // register port geometry
  localparam int unsigned DSGC_ADDR_W = 12;
  localparam int unsigned DSGC_DATA_W = 32;
  localparam int unsigned DSGC_NUM_UNITS = 6;

  // register offsets (byte addresses)
  localparam logic [11:0] DSGC_OFF_DEEP = 12'h124;
  localparam logic [11:0] DSGC_OFF_RUN = 12'h180;
  localparam logic [11:0] DSGC_OFF_SLEEP = 12'h184;
  localparam logic [11:0] DSGC_OFF_CFG = 12'h188;
  localparam logic [11:0] DSGC_OFF_STAT = 12'h190;
  localparam logic [11:0] DSGC_OFF_MASK = 12'h194;

  // gate bit positions, shared by all three copies, status and mask
  localparam int unsigned DSGC_POS_ASYNC_A = 0;
  localparam int unsigned DSGC_POS_SYNC_A = 4;
  localparam int unsigned DSGC_POS_CNT_A = 16;
  localparam int unsigned DSGC_POS_CNT_B = 17;
  localparam int unsigned DSGC_POS_CNT_C = 18;
  localparam int unsigned DSGC_POS_CMP_A = 24;
  localparam int unsigned DSGC_UNIT_POS [0:5] = '{
    DSGC_POS_ASYNC_A, DSGC_POS_SYNC_A, DSGC_POS_CNT_A,
    DSGC_POS_CNT_B, DSGC_POS_CNT_C, DSGC_POS_CMP_A
  };

  // auto sleep gating select bit inside the run clock configuration
  localparam int unsigned DSGC_POS_AUTO = 0;

  // writable bits of a gate word; everything else reads zero
  localparam logic [31:0] DSGC_GATE_WMASK = 32'h0107_0011;

  // reset values
  localparam logic [31:0] DSGC_RST_GATE = 32'h0000_0000;
  localparam logic [31:0] DSGC_RST_CFG = 32'h0000_0000;
  localparam logic [5:0] DSGC_RST_UNITS = 6'h00;

  // operating state, gray coded along run -> sleep -> deep sleep
  typedef enum logic [1:0] {
    DSGC_MODE_RUN = 2'b00,
    DSGC_MODE_SLEEP = 2'b01,
    DSGC_MODE_DEEP = 2'b11
  } dsgc_mode_t;

  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dsgc_bus_req_t;

  // one flag per controlled unit, index 5 first, index 0 last
  typedef struct packed {
    logic comparator_a_gate;
    logic gp_counter_c_gate;
    logic gp_counter_b_gate;
    logic gp_counter_a_gate;
    logic sync_serial_a_gate;
    logic async_serial_a_gate;
  } dsgc_unit_t;

endpackage

// [verilog/dsgc_clk_gate.sv]
// latch based glitch free clock gate cell for one unit
`timescale 1ns/10ps
module dsgc_clk_gate (
  input wire logic clk_in, // free running clock
  input wire logic enable_in, // enable from a flop on clk_in
  output logic gclk_out // gated clock to the unit
);

  logic en_lat; // enable held through the high phase

  // transparent only while the clock is low, so a change of enable
  // can never cut a high pulse short
  always_latch begin
    if (!clk_in) begin
      en_lat = enable_in;
    end
  end

  // and gate after the latch
  assign gclk_out = clk_in & en_lat;

endmodule

// [verilog/dsgc_ctl.sv]
// deep sleep clock gate control with run and sleep copies
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps

module dsgc_ctl (
  input wire logic clk_sys_in, // system clock, 100 MHz
  input wire logic reset_in, // async reset, active high
  input wire dsgc_pkg::dsgc_bus_req_t bus_req_in, // register port
  output logic [31:0] rdata_out, // read data, cycle after strobe
  input wire dsgc_pkg::dsgc_mode_t power_mode_in, // operating state
  input wire dsgc_pkg::dsgc_unit_t unit_access_in, // unit selected
  output dsgc_pkg::dsgc_unit_t unit_enable_out, // unit enabled
  output logic [5:0] unit_clk_out, // gated unit clocks
  output logic bus_fault_out, // fault answer pulse
  output logic irq_out // level interrupt
);
  import dsgc_pkg::*;

  // gate copies as stored, writable bits only
  logic [31:0] run_gate_reg; // run copy
  logic [31:0] sleep_gate_reg; // sleep copy
  logic [31:0] deep_gate_reg; // deep sleep copy
  logic [31:0] cfg_reg; // run clock configuration
  logic auto_gate; // auto sleep gating select

  // selected word and per unit enables
  logic [31:0] sel_word; // copy that applies now
  logic [5:0] en_next; // enables for next cycle
  logic [5:0] en_reg; // enables as delivered

  // fault and interrupt state
  logic [5:0] access_vec; // accesses as a vector
  logic [5:0] hit_gated; // access to a stopped unit
  logic fault_next; // fault answer next cycle
  logic fault_reg; // fault answer
  logic [5:0] stat_reg; // sticky fault flags
  logic [5:0] stat_next; // flags next value
  logic [5:0] mask_reg; // interrupt mask
  logic irq_reg; // interrupt level

  // register port decode
  logic wr_run; // write to run copy
  logic wr_sleep; // write to sleep copy
  logic wr_deep; // write to deep sleep copy
  logic wr_cfg; // write to configuration
  logic wr_stat; // write one to clear
  logic wr_mask; // write to mask
  logic [31:0] rdata_next; // read data next value
  logic [31:0] rdata_reg; // read data

  // spread six unit flags onto their word positions
  function automatic logic [31:0] units_to_word(input logic [5:0] u);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < 6; i++) begin
      w[DSGC_UNIT_POS[i]] = u[i];
    end
    return w;
  endfunction

  // gather six unit flags from their word positions
  function automatic logic [5:0] word_to_units(input logic [31:0] w);
    logic [5:0] u;
    u = 6'h00;
    for (int i = 0; i < 6; i++) begin
      u[i] = w[DSGC_UNIT_POS[i]];
    end
    return u;
  endfunction

  // write decode, if chain on the address
  always_comb begin
    wr_run = 1'b0;
    wr_sleep = 1'b0;
    wr_deep = 1'b0;
    wr_cfg = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (!bus_req_in.wr) begin
      // no write this cycle
    end else if (bus_req_in.addr == DSGC_OFF_DEEP) begin
      wr_deep = 1'b1;
    end else if (bus_req_in.addr == DSGC_OFF_RUN) begin
      wr_run = 1'b1;
    end else if (bus_req_in.addr == DSGC_OFF_SLEEP) begin
      wr_sleep = 1'b1;
    end else if (bus_req_in.addr == DSGC_OFF_CFG) begin
      wr_cfg = 1'b1;
    end else if (bus_req_in.addr == DSGC_OFF_STAT) begin
      wr_stat = 1'b1;
    end else if (bus_req_in.addr == DSGC_OFF_MASK) begin
      wr_mask = 1'b1;
    end
  end

  // the three gate copies; reserved bits are never stored
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      run_gate_reg <= DSGC_RST_GATE;
      sleep_gate_reg <= DSGC_RST_GATE;
      deep_gate_reg <= DSGC_RST_GATE;
    end else begin
      if (wr_run) begin
        run_gate_reg <= bus_req_in.wdata & DSGC_GATE_WMASK;
      end
      if (wr_sleep) begin
        sleep_gate_reg <= bus_req_in.wdata & DSGC_GATE_WMASK;
      end
      if (wr_deep) begin
        // bits 0, 4, 16..18 and 24 only
        deep_gate_reg <= bus_req_in.wdata & DSGC_GATE_WMASK;
      end
    end
  end

  // run clock configuration; only the auto select bit is kept
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_reg <= DSGC_RST_CFG;
    end else if (wr_cfg) begin
      cfg_reg <= 32'h0000_0000;
      cfg_reg[DSGC_POS_AUTO] <= bus_req_in.wdata[DSGC_POS_AUTO];
    end
  end

  assign auto_gate = cfg_reg[DSGC_POS_AUTO];

  // pick the copy for the present operating state
  always_comb begin
    case (power_mode_in)
      DSGC_MODE_SLEEP: begin
        // without auto gating the run copy stays in force
        sel_word = auto_gate ? sleep_gate_reg : run_gate_reg;
      end
      DSGC_MODE_DEEP: begin
        sel_word = auto_gate ? deep_gate_reg : run_gate_reg;
      end
      default: begin
        sel_word = run_gate_reg;
      end
    endcase
  end

  // one enable per unit from its own bit position
  assign en_next = word_to_units(sel_word);

  // enable flops; a flop keeps the gate latch input glitch free
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      en_reg <= DSGC_RST_UNITS;
    end else begin
      en_reg <= en_next;
    end
  end

  // one latch gate per unit clock
  genvar gi;
  generate
    for (gi = 0; gi < DSGC_NUM_UNITS; gi++) begin : g_gate
      dsgc_clk_gate u_gate (
        .clk_in(clk_sys_in),
        .enable_in(en_reg[gi]),
        .gclk_out(unit_clk_out[gi])
      );
    end
  endgenerate

  // enables also hold each unit disabled while unclocked
  assign unit_enable_out = dsgc_unit_t'(en_reg);

  // an access to a unit whose clock is stopped faults
  assign access_vec = 6'(unit_access_in);
  assign hit_gated = access_vec & ~en_reg;
  assign fault_next = |hit_gated;

  // fault answer, one cycle after the access
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // sticky fault flags; a new fault wins over a clear
  always_comb begin
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & ~word_to_units(bus_req_in.wdata);
    end
    stat_next = stat_next | hit_gated;
  end

  // status and mask flops
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      stat_reg <= DSGC_RST_UNITS;
      mask_reg <= DSGC_RST_UNITS;
    end else begin
      stat_reg <= stat_next;
      if (wr_mask) begin
        mask_reg <= word_to_units(bus_req_in.wdata);
      end
    end
  end

  // interrupt follows the next status so it lags a flag by nothing
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      irq_reg <= 1'b0;
    end else if (wr_mask) begin
      irq_reg <= |(stat_next & word_to_units(bus_req_in.wdata));
    end else begin
      irq_reg <= |(stat_next & mask_reg);
    end
  end

  // read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (!bus_req_in.rd) begin
      // no read this cycle
    end else if (bus_req_in.addr == DSGC_OFF_DEEP) begin
      rdata_next = deep_gate_reg;
    end else if (bus_req_in.addr == DSGC_OFF_RUN) begin
      rdata_next = run_gate_reg;
    end else if (bus_req_in.addr == DSGC_OFF_SLEEP) begin
      rdata_next = sleep_gate_reg;
    end else if (bus_req_in.addr == DSGC_OFF_CFG) begin
      rdata_next = cfg_reg;
    end else if (bus_req_in.addr == DSGC_OFF_STAT) begin
      rdata_next = units_to_word(stat_reg);
    end else if (bus_req_in.addr == DSGC_OFF_MASK) begin
      rdata_next = units_to_word(mask_reg);
    end
  end

  // read data register; zero outside the answer cycle
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flops
  assign rdata_out = rdata_reg;
  assign bus_fault_out = fault_reg;
  assign irq_out = irq_reg;

  // checks, all on the system clock
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  // an access that hits a stopped unit
  sequence s_gated_hit;
    |(access_vec & ~en_reg);
  endsequence

  // the fault shows and the flag is raised
  sequence s_fault_seen;
    bus_fault_out && (stat_reg != 6'h00);
  endsequence

  chk_fault_gated: assert property (
    s_gated_hit |=> s_fault_seen)
    else $error("no bus fault after access to a gated unit");

  chk_fault_clean: assert property (
    !(|(access_vec & ~en_reg)) |=> !bus_fault_out)
    else $error("bus fault without access to a gated unit");

  chk_reset_clear: assert property (
    disable iff (1'b0)
    reset_in |-> (deep_gate_reg == 32'h0000_0000) && (en_reg == 6'h00))
    else $error("gate state not cleared under reset");

  chk_deep_select: assert property (
    (power_mode_in == DSGC_MODE_DEEP) && auto_gate
    |=> en_reg == word_to_units($past(deep_gate_reg)))
    else $error("deep sleep copy not applied");

  chk_auto_off: assert property (
    !auto_gate |=> en_reg == word_to_units($past(run_gate_reg)))
    else $error("sleep copy applied without auto gating");

  chk_deep_write: assert property (
    bus_req_in.wr && (bus_req_in.addr == DSGC_OFF_DEEP)
    |=> deep_gate_reg == ($past(bus_req_in.wdata) & DSGC_GATE_WMASK))
    else $error("deep sleep copy write not stored");

  chk_reserved_zero: assert property (
    bus_req_in.rd |=> (rdata_out & ~DSGC_GATE_WMASK) == 32'h0000_0000
      || $past(bus_req_in.addr) == DSGC_OFF_CFG)
    else $error("reserved bits read nonzero");

  // every cycle the delivered enables are the copy selected a cycle ago
  chk_unit_enable: assert property (
    1'b1
    |=> unit_enable_out == dsgc_unit_t'(word_to_units($past(sel_word))))
    else $error("unit enable does not follow selected copy");

  // a mask write in the same cycle decides for itself, so leave it out
  chk_irq_level: assert property (
    s_gated_hit ##0 (mask_reg == 6'h3f) ##0 !wr_mask |=> irq_out)
    else $error("unmasked fault raised no interrupt");

  // a flag raised by a fault survives a clear in the same cycle
  chk_stat_sticky: assert property (
    s_gated_hit |=> (stat_reg & $past(hit_gated)) == $past(hit_gated))
    else $error("fault flag not held after a gated access");

  // read data stands for the answer cycle only
  chk_rdata_idle: assert property (
    !bus_req_in.rd |=> rdata_out == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  // sleep copy in force while asleep with auto gating
  chk_sleep_select: assert property (
    (power_mode_in == DSGC_MODE_SLEEP) && auto_gate
    |=> en_reg == word_to_units($past(sleep_gate_reg)))
    else $error("sleep copy not applied");

  // the level drops as soon as no unmasked flag is left
  chk_irq_clear: assert property (
    (stat_reg & mask_reg) == 6'h00 |-> !irq_out)
    else $error("interrupt without an unmasked flag");

endmodule

// [verif/deep_sleep_clock_gate_ctl_tb_top.sv]
// self checking bench for the deep sleep clock gate control block
`timescale 1ns/10ps
module deep_sleep_clock_gate_ctl_tb_top;
  import dsgc_pkg::*;
  logic clk_sys_in; // system clock
  logic reset_in; // async reset
  dsgc_bus_req_t req; // register port request
  logic [31:0] rdata_out; // read data
  dsgc_mode_t mode; // operating state
  dsgc_unit_t access; // unit access strobes
  dsgc_unit_t unit_enable_out; // unit enables
  logic [5:0] unit_clk_out; // gated clocks
  logic bus_fault_out; // fault pulse
  logic irq_out; // interrupt level
  int bad_count; // mismatches
  int n_checks; // comparisons made
  int cycles; // timeout counter
  logic [31:0] d; // scratch read data
  logic [11:0] offs [0:5]; // every mapped register
  dsgc_ctl dsgc_ctl_inst (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .bus_req_in(req),
    .rdata_out(rdata_out),
    .power_mode_in(mode),
    .unit_access_in(access),
    .unit_enable_out(unit_enable_out),
    .unit_clk_out(unit_clk_out),
    .bus_fault_out(bus_fault_out),
    .irq_out(irq_out)
  );
  // 100 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // verdict and stop, one place only
  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write cycle; strobe dropped at the sampling edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk_sys_in);
    req.wr <= 1'b0;
  endtask
  // one read cycle; data taken in the following cycle only
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys_in);
    req.rd <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask
  // let copy or mode changes reach the enables
  task automatic settle();
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
  // gate word to unit flags, via the shared bit positions
  function automatic logic [5:0] units(input logic [31:0] w);
    logic [5:0] u;
    for (int i = 0; i < 6; i++) u[i] = w[DSGC_UNIT_POS[i]];
    return u;
  endfunction
  // enables and both clock phases against one gate word
  task automatic chk_gate(input logic [31:0] w);
    chk(32'(unit_enable_out), 32'(units(w)));
    chk(32'(unit_clk_out), 32'(units(w))); // high phase gives clock
    @(negedge clk_sys_in);
    #1;
    chk(32'(unit_clk_out), 32'h0);
    // hand back on a rising edge so the next input change sits there
    @(posedge clk_sys_in);
  endtask
  // one access strobe to unit i, fault answer one cycle later
  task automatic hit(input int i, input logic f);
    @(posedge clk_sys_in);
    access <= dsgc_unit_t'(6'h01 << i);
    @(posedge clk_sys_in);
    access <= dsgc_unit_t'(6'h00);
    #1;
    chk(32'(bus_fault_out), 32'(f));
  endtask
  // hang guard; the sequence needs under two hundred cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    offs = '{DSGC_OFF_DEEP, DSGC_OFF_RUN, DSGC_OFF_SLEEP, DSGC_OFF_CFG,
             DSGC_OFF_STAT, DSGC_OFF_MASK};
    // non-blocking, so the reset flops see the rise at time zero
    reset_in <= 1'b1;
    req <= '0;
    mode <= DSGC_MODE_RUN;
    access <= dsgc_unit_t'(6'h00);
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    #1;
    chk(32'(unit_enable_out), 32'h0);
    chk(32'(irq_out), 32'h0);
    for (int i = 0; i < 6; i++) rd(offs[i], 32'h0);
    rd(12'h200, 32'h0);
    // only the six gate bits hold a one; reserved bits read zero
    for (int i = 0; i < 3; i++) begin
      wr(offs[i], 32'hffff_ffff);
      rd(offs[i], DSGC_GATE_WMASK);
    end
    wr(DSGC_OFF_DEEP, 32'h0107_0000);
    rd(DSGC_OFF_DEEP, 32'h0107_0000);
    wr(DSGC_OFF_RUN, 32'h0000_0001);
    wr(DSGC_OFF_SLEEP, 32'h0000_0010);
    // without automatic select the run copy rules every state
    mode <= DSGC_MODE_DEEP;
    settle();
    chk_gate(32'h0000_0001);
    wr(DSGC_OFF_CFG, 32'h0000_0001);
    settle();
    chk_gate(32'h0107_0000);
    mode <= DSGC_MODE_SLEEP;
    settle();
    chk_gate(32'h0000_0010);
    mode <= DSGC_MODE_RUN;
    settle();
    chk_gate(32'h0000_0001);
    // the unused state code behaves as run
    mode <= dsgc_mode_t'(2'b10);
    settle();
    chk_gate(32'h0000_0001);
    // one unit at a time in deep sleep; a stopped neighbour faults
    mode <= DSGC_MODE_DEEP;
    for (int i = 0; i < 6; i++) begin
      wr(DSGC_OFF_DEEP, 32'h1 << DSGC_UNIT_POS[i]);
      settle();
      chk_gate(32'h1 << DSGC_UNIT_POS[i]);
      hit(i, 1'b0);
      hit((i + 1) % 6, 1'b1);
      chk(32'(irq_out), 32'h0);
    end
    rd(DSGC_OFF_STAT, DSGC_GATE_WMASK);
    // unmask, then clear flags one and all
    wr(DSGC_OFF_MASK, 32'hffff_ffff);
    settle();
    chk(32'(irq_out), 32'h1);
    wr(DSGC_OFF_STAT, 32'h0000_0001);
    rd(DSGC_OFF_STAT, DSGC_GATE_WMASK & 32'hffff_fffe);
    wr(DSGC_OFF_STAT, 32'hffff_ffff);
    settle();
    chk(32'(irq_out), 32'h0);
    hit(1, 1'b1);
    settle();
    chk(32'(irq_out), 32'h1);
    wr(DSGC_OFF_MASK, 32'h0000_0001);
    settle();
    chk(32'(irq_out), 32'h0);
    // back to reset values after a second reset
    @(posedge clk_sys_in);
    reset_in <= 1'b1;
    @(posedge clk_sys_in);
    reset_in <= 1'b0;
    #1;
    chk(32'(unit_enable_out), 32'h0);
    rd(DSGC_OFF_DEEP, 32'h0);
    // set one more unit by read, modify and write back
    wr(DSGC_OFF_DEEP, 32'h0000_0010);
    rd(DSGC_OFF_DEEP, 32'h0000_0010);
    d = rdata_out;
    wr(DSGC_OFF_DEEP, d | 32'h0000_0001);
    rd(DSGC_OFF_DEEP, 32'h0000_0011);
    end_sim();
  end
endmodule
